/* verilog/video_output_ancillary_inserter.sv */
// Purpose: line-locked 8-bit video output with ancillary insertion
// Assumes: pix_clk_in from the output PLL, far slower than clk
// Notes: data and pins change on the selected pixel clock edge
// Summary of operation
// - slicer bytes pass unchanged, no added header or trailer
// - ancillary bytes only between end and start of active video codes
// - insert on next allowed line; 525 skips 9-11, 272-274
// - 625 never inserts on 5-7, 318-320; defer instead
// - bytes start right after end code, replace blanking, keep order
// - at most 84 bytes per output line; a longer source line continues on the next allowed line
// - pixels per line 1716, 1728, 1560 or 1888 by standard and mode
// - phase jumps change line length; if disabled, frequency correction
// - phase jump disable bit resets to jumps allowed
// - a bit selects rising or falling active pixel clock edge
// - field, vsync, hsync, lock, data change on active edge
// - the pixel clock also paces reads of the output FIFO
// - override pairs force lock, hsync, vsync, field to value bits
// - after reset all pins carry primary functions
// - enable bit turns lock pin into masked interrupt request
// - clipping limits luma to 16-235 and chroma to 16-240
// - control bit forces interlaced timing, else follows input
// - bypass bit leaves active section unblanked during vertical blanking
// - hsync pin can be delayed by enable and 2-bit delay
// - two blanking bits and two chroma attenuation settings
// - vsync mode bit selects digital or analog vsync generation
// - digital vsync changes at line start; analog also mid-line
// - unused active positions in blanking carry 80h 10h 80h 10h
`timescale 1ns/10ps
`default_nettype none
module video_output_ancillary_inserter (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pix_clk_in,
    input wire logic std_625,
    input wire logic square_pix,
    input wire logic [7:0] vid_in,
    input wire logic field_in,
    input wire logic pll_lock,
    input wire logic phase_jump,
    input wire logic signed [3:0] jump_delta,
    input wire logic anc_valid,
    output logic anc_ready,
    input wire logic [7:0] anc_data,
    input wire logic anc_last,
    input wire logic vsync_mode_sel,
    input wire logic phase_jump_disable,
    input wire logic clock_edge_sel,
    input wire logic force_interlace_en,
    input wire logic vbi_bypass_en,
    input wire logic hsync_delay_en,
    input wire logic [1:0] hsync_delay_sel,
    input wire logic blank_behaviour_a,
    input wire logic blank_behaviour_b,
    input wire logic no_signal,
    input wire logic [1:0] atten_cb,
    input wire logic [1:0] atten_cr,
    input wire logic clip_en,
    input wire logic [7:0] pin_override_bits,
    input wire logic irq_on_lock_pin_en,
    input wire logic [7:0] irq_sources,
    input wire logic [7:0] irq_mask,
    output logic pix_clk_out,
    output logic [7:0] video_data_out,
    output logic hsync_pin,
    output logic vsync_pin,
    output logic field_pin,
    output logic lock_pin,
    output logic pll_fm_corr,
    output logic signed [3:0] pll_fm_delta
);
    logic pclk_s1;
    logic pclk_s2;
    logic pclk_s3;
    logic act;
    logic [10:0] hcnt;
    logic [9:0] lcnt;
    logic signed [3:0] jump_pend;
    logic [10:0] line_len;
    logic [10:0] sav_beg;
    logic [10:0] act_beg;
    logic [9:0] frame_lines;
    logic in_vbi;
    logic forbidden;
    logic f_gen;
    logic anc_on;
    logic [7:0] anc_cnt;
    logic pop;
    logic fifo_valid;
    logic [8:0] fifo_data;
    logic [7:0] next_data;
    logic [3:0] hs_pipe;
    logic hs_int;
    logic vs_int;
    logic fld;
    logic out_active;
    logic out_vbi_blank;
    logic out_blank;

    function automatic logic [7:0] xy_code(input logic f, input logic v, input logic h);
        xy_code = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction

    function automatic logic [7:0] clip(input logic [7:0] c, input logic [7:0] hi);
        clip = (c < vout_pkg::CODE_MIN) ? vout_pkg::CODE_MIN : ((c > hi) ? hi : c);
    endfunction

    function automatic logic [7:0] atten(input logic [7:0] c, input logic [1:0] sh);
        logic signed [8:0] d;
        d = 9'(c) - 9'(vout_pkg::BLANK_C);
        atten = 8'(vout_pkg::BLANK_C + 8'(d >>> sh));
    endfunction

    function automatic logic in_span(input logic [9:0] l, input logic [9:0] a, input logic [9:0] b);
        in_span = (l >= a) && (l <= b);
    endfunction

    // two-stage sync of the pixel clock, edge found on later stages
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pclk_s1 <= 1'b0;
            pclk_s2 <= 1'b0;
            pclk_s3 <= 1'b0;
        end
        else
        begin
            pclk_s1 <= pix_clk_in;
            pclk_s2 <= pclk_s1;
            pclk_s3 <= pclk_s2;
        end
    end

    assign act = clock_edge_sel ? (!pclk_s2 && pclk_s3) : (pclk_s2 && !pclk_s3);
    assign pix_clk_out = pclk_s3;

    always_comb
    begin
        unique case ({std_625, square_pix})
            2'b00:
            begin
                line_len = vout_pkg::LEN_525N;
                act_beg = vout_pkg::LEN_525N - vout_pkg::ACT_N;
            end
            2'b10:
            begin
                line_len = vout_pkg::LEN_625N;
                act_beg = vout_pkg::LEN_625N - vout_pkg::ACT_N;
            end
            2'b11:
            begin
                line_len = vout_pkg::LEN_625S;
                act_beg = vout_pkg::LEN_625S - vout_pkg::ACT_625S;
            end
            2'b01:
            begin
                line_len = vout_pkg::LEN_525S;
                act_beg = vout_pkg::LEN_525S - vout_pkg::ACT_525S;
            end
        endcase
        frame_lines = std_625 ? vout_pkg::LINES_625 : vout_pkg::LINES_525;
    end

    assign sav_beg = act_beg - vout_pkg::CODE_LEN;

    // pixel and line counters; a pending jump lengthens or shortens one line
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            hcnt <= '0;
            lcnt <= 10'h001;
        end
        else if (act)
        begin
            if (hcnt >= 11'(line_len + 11'(signed'(jump_pend)) - 11'h001))
            begin
                hcnt <= '0;
                lcnt <= (lcnt >= frame_lines) ? 10'h001 : lcnt + 10'h001;
            end
            else
            begin
                hcnt <= hcnt + 11'h001;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            jump_pend <= '0;
            pll_fm_corr <= 1'b0;
            pll_fm_delta <= '0;
        end
        else
        begin
            pll_fm_corr <= phase_jump && phase_jump_disable;
            if (phase_jump && phase_jump_disable)
            begin
                pll_fm_delta <= jump_delta;
            end
            if (phase_jump && !phase_jump_disable)
            begin
                jump_pend <= jump_delta;
            end
            else if (act && hcnt == '0)
            begin
                jump_pend <= '0;
            end
        end
    end

    always_comb
    begin
        if (std_625)
        begin
            in_vbi = in_span(lcnt, 10'h001, vout_pkg::VBI1_END_625)
                || in_span(lcnt, vout_pkg::VBI2_BEG_625, vout_pkg::VBI2_END_625)
                || lcnt >= vout_pkg::VBI3_BEG_625;
            forbidden = in_span(lcnt, vout_pkg::FORB1_625, vout_pkg::FORB1_625 + vout_pkg::FORB_SPAN)
                || in_span(lcnt, vout_pkg::FORB2_625, vout_pkg::FORB2_625 + vout_pkg::FORB_SPAN);
            f_gen = lcnt >= vout_pkg::F2_BEG_625;
        end
        else
        begin
            in_vbi = in_span(lcnt, 10'h001, vout_pkg::VBI1_END_525)
                || in_span(lcnt, vout_pkg::VBI2_BEG_525, vout_pkg::VBI2_END_525);
            forbidden = in_span(lcnt, vout_pkg::FORB1_525, vout_pkg::FORB1_525 + vout_pkg::FORB_SPAN)
                || in_span(lcnt, vout_pkg::FORB2_525, vout_pkg::FORB2_525 + vout_pkg::FORB_SPAN);
            f_gen = lcnt >= vout_pkg::F2_BEG_525;
        end
    end

    // slicer bytes wait here until an allowed line; pops follow the pixel clock
    vout_fifo #(
        .W(vout_pkg::ANC_W),
        .D(vout_pkg::FIFO_DEPTH)
    ) vout_fifo_inst (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(anc_valid),
        .in_ready(anc_ready),
        .in_data({anc_last, anc_data}),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_data)
    );

    assign pop = act && anc_on && fifo_valid && hcnt < sav_beg;

    // one packet per line: opened after the end code, closed on last byte, 84th byte or start code
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            anc_on <= 1'b0;
            anc_cnt <= '0;
        end
        else if (act)
        begin
            if (hcnt == vout_pkg::CODE_LEN - 11'h001)
            begin
                anc_on <= fifo_valid && !forbidden;
                anc_cnt <= '0;
            end
            else if (pop)
            begin
                anc_cnt <= anc_cnt + 8'h01;
                if (fifo_data[8] || anc_cnt == vout_pkg::ANC_MAX - 8'h01)
                begin
                    anc_on <= 1'b0;
                end
            end
            else if (hcnt >= sav_beg)
            begin
                anc_on <= 1'b0;
            end
        end
    end

    assign fld = force_interlace_en ? f_gen : field_in;
    assign out_blank = (blank_behaviour_a && no_signal) || blank_behaviour_b;

    always_comb
    begin
        logic [10:0] ai;
        logic [7:0] c;
        ai = hcnt - act_beg;
        c = vid_in;
        next_data = ai[0] ? vout_pkg::BLANK_Y : vout_pkg::BLANK_C;
        if (hcnt < vout_pkg::CODE_LEN)
        begin
            next_data = (hcnt == '0) ? vout_pkg::PRE_FF : vout_pkg::PRE_00;
            if (hcnt == vout_pkg::CODE_LEN - 11'h001)
            begin
                next_data = xy_code(fld, in_vbi, 1'b1);
            end
        end
        else if (hcnt < sav_beg)
        begin
            next_data = hcnt[0] ? vout_pkg::BLANK_Y : vout_pkg::BLANK_C;
            if (pop)
            begin
                next_data = fifo_data[7:0];
            end
        end
        else if (hcnt < act_beg)
        begin
            next_data = (hcnt == sav_beg) ? vout_pkg::PRE_FF : vout_pkg::PRE_00;
            if (hcnt == act_beg - 11'h001)
            begin
                next_data = xy_code(fld, in_vbi, 1'b0);
            end
        end
        else if (!((in_vbi && !vbi_bypass_en) || out_blank))
        begin
            if (!ai[0])
            begin
                c = atten(vid_in, ai[1] ? atten_cr : atten_cb);
            end
            if (clip_en)
            begin
                c = clip(c, ai[0] ? vout_pkg::Y_MAX : vout_pkg::C_MAX);
            end
            next_data = c;
        end
    end

    assign hs_int = hcnt < vout_pkg::HS_WIDTH;

    always_comb
    begin
        logic [9:0] v1;
        logic [9:0] v2;
        logic half;
        v1 = std_625 ? vout_pkg::VS1_625 : vout_pkg::VS1_525;
        v2 = std_625 ? vout_pkg::VS2_625 : vout_pkg::VS2_525;
        half = hcnt >= (line_len >> 1);
        vs_int = in_span(lcnt, v1, v1 + vout_pkg::VS_LINES - 10'h001);
        if (vsync_mode_sel)
        begin
            vs_int = vs_int || (lcnt == v2 && half)
                || in_span(lcnt, v2 + 10'h001, v2 + vout_pkg::VS_LINES - 10'h001)
                || (lcnt == v2 + vout_pkg::VS_LINES && !half);
        end
        else
        begin
            vs_int = vs_int || in_span(lcnt, v2, v2 + vout_pkg::VS_LINES - 10'h001);
        end
    end

    // the hsync, vsync, field and lock pins and the data bus move only on the active edge
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            video_data_out <= vout_pkg::BLANK_C;
            hs_pipe <= '0;
            hsync_pin <= 1'b0;
            vsync_pin <= 1'b0;
            field_pin <= 1'b0;
            lock_pin <= 1'b0;
            out_active <= 1'b0;
            out_vbi_blank <= 1'b0;
        end
        else if (act)
        begin
            video_data_out <= next_data;
            hs_pipe <= {hs_pipe[2:0], hs_int};
            out_active <= hcnt >= act_beg && !out_blank;
            out_vbi_blank <= hcnt >= act_beg && in_vbi && !vbi_bypass_en;
            if (pin_override_bits[2])
                hsync_pin <= pin_override_bits[3];
            else
                hsync_pin <= hsync_delay_en ? hs_pipe[hsync_delay_sel] : hs_int;
            if (pin_override_bits[4])
                vsync_pin <= pin_override_bits[5];
            else
                vsync_pin <= vs_int;
            if (pin_override_bits[6])
                field_pin <= pin_override_bits[7];
            else
                field_pin <= fld;
            if (pin_override_bits[0])
                lock_pin <= pin_override_bits[1];
            else if (irq_on_lock_pin_en)
                lock_pin <= |(irq_sources & irq_mask);
            else
                lock_pin <= pll_lock;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    anc_window_a: assert property (pop |-> hcnt >= vout_pkg::CODE_LEN && hcnt < sav_beg)
        else $error("ancillary byte outside blanking");
    anc_forbid_a: assert property (pop |-> !forbidden)
        else $error("ancillary byte on forbidden line");
    anc_count_a: assert property (anc_cnt <= vout_pkg::ANC_MAX)
        else $error("too many ancillary bytes in a line");
    anc_pass_a: assert property (pop |=> video_data_out == $past(fifo_data[7:0]))
        else $error("ancillary byte altered");
    pin_override_a: assert property (act && pin_override_bits[0] |=> lock_pin == $past(pin_override_bits[1]))
        else $error("override value not on lock pin");
    clip_range_a: assert property (clip_en && out_active && !out_vbi_blank |-> video_data_out >= vout_pkg::CODE_MIN && video_data_out <= vout_pkg::C_MAX)
        else $error("clipped code out of range");
    edge_only_a: assert property ($changed(video_data_out) |-> $past(act))
        else $error("data changed off the active edge");
    vbi_blank_a: assert property (out_vbi_blank |-> video_data_out == vout_pkg::BLANK_C || video_data_out == vout_pkg::BLANK_Y)
        else $error("blanking pattern missing");
    fm_corr_a: assert property (phase_jump && phase_jump_disable |=> pll_fm_corr && jump_pend == $past(jump_pend))
        else $error("disabled phase jump not turned into correction");
endmodule
`default_nettype wire

/* inc/vout_pkg.sv */
// Purpose: constants shared by the video output stage
// Assumes: pixel clock sampled by clk; line numbers count from 1
// Notes: figures are line, pixel or byte counts, 8-bit code values or widths
package vout_pkg;
    localparam logic [10:0] LEN_525N = 11'h6B4;
    localparam logic [10:0] LEN_625N = 11'h6C0;
    localparam logic [10:0] LEN_625S = 11'h760;
    localparam logic [10:0] LEN_525S = 11'h618;
    localparam logic [10:0] ACT_N = 11'h5A0;
    localparam logic [10:0] ACT_625S = 11'h600;
    localparam logic [10:0] ACT_525S = 11'h500;
    localparam logic [10:0] CODE_LEN = 11'h004;
    localparam logic [9:0] LINES_525 = 10'h20D;
    localparam logic [9:0] LINES_625 = 10'h271;
    localparam logic [9:0] FORB1_525 = 10'h009;
    localparam logic [9:0] FORB2_525 = 10'h110;
    localparam logic [9:0] FORB1_625 = 10'h005;
    localparam logic [9:0] FORB2_625 = 10'h13E;
    localparam logic [9:0] FORB_SPAN = 10'h002;
    localparam logic [9:0] VBI1_END_525 = 10'h013;
    localparam logic [9:0] VBI2_BEG_525 = 10'h108;
    localparam logic [9:0] VBI2_END_525 = 10'h11A;
    localparam logic [9:0] VBI1_END_625 = 10'h016;
    localparam logic [9:0] VBI2_BEG_625 = 10'h137;
    localparam logic [9:0] VBI2_END_625 = 10'h14F;
    localparam logic [9:0] VBI3_BEG_625 = 10'h270;
    localparam logic [9:0] F2_BEG_525 = 10'h108;
    localparam logic [9:0] F2_BEG_625 = 10'h139;
    localparam logic [9:0] VS1_525 = 10'h004;
    localparam logic [9:0] VS2_525 = 10'h10A;
    localparam logic [9:0] VS1_625 = 10'h001;
    localparam logic [9:0] VS2_625 = 10'h139;
    localparam logic [9:0] VS_LINES = 10'h003;
    localparam logic [10:0] HS_WIDTH = 11'h080;
    localparam logic [7:0] ANC_MAX = 8'h54;
    localparam logic [7:0] CODE_MIN = 8'h10;
    localparam logic [7:0] Y_MAX = 8'hEB;
    localparam logic [7:0] C_MAX = 8'hF0;
    localparam logic [7:0] BLANK_C = 8'h80;
    localparam logic [7:0] BLANK_Y = 8'h10;
    localparam logic [7:0] PRE_FF = 8'hFF;
    localparam logic [7:0] PRE_00 = 8'h00;
    localparam int FIFO_DEPTH = 4;
    localparam int ANC_W = 9;
endpackage

/* verilog/vout_fifo.sv */
// Purpose: small flop FIFO between slicer and output stage
// Assumes: both sides on clk
// Notes: full and empty are exact; in_ready drops when full
`timescale 1ns/10ps
`default_nettype none
module vout_fifo #(
    parameter int W = 9,
    parameter int D = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(D));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(D - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= bump(wr_ptr);
            end
            if (pop)
            begin
                rd_ptr <= bump(rd_ptr);
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

/* verif/video_rx_model.sv */
// Purpose: downstream receiver capturing the first bytes after the first two EAV codes
// Assumes: rising active edge, so bytes are taken at the falling edge
// Notes: keeps the bytes that follow the first two EAV codes
`timescale 1ns/10ps
`default_nettype none
module video_rx_model (
    input wire logic pix_clk_out,
    input wire logic [7:0] video_data_out,
    output logic [1:0] eav_count,
    output logic [7:0] cap [0:179],
    output int line_px
);
    logic [23:0] hist = 24'h000000;
    int n = 0;
    int pos = 200;
    int base = 0;
    initial eav_count = 2'h0;
    // mid-period sample, away from the data change
    always @(negedge pix_clk_out)
    begin
        n = n + 1;
        if (pos < 90)
        begin
            cap[base + pos] = video_data_out;
            pos = pos + 1;
        end
        // FF 00 00 then XY with H set marks an end code
        if (hist == 24'hFF0000 && video_data_out[7] && video_data_out[4] && eav_count < 2)
        begin
            // pixels from the first end code to the second: one whole line
            if (eav_count == 2'h1)
                line_px = n;
            n = 0;
            base = int'(eav_count) * 90;
            eav_count = eav_count + 2'h1;
            pos = 0;
        end
        hist = {hist[15:0], video_data_out};
    end
endmodule
`default_nettype wire

/* verif/video_output_ancillary_inserter_tb_top.sv */
// Purpose: self-checking bench for the video output stage
// Assumes: 525-line normal pixel mode, rising active edge
// Notes: run covers the first output line and the start of the second
`timescale 1ns/10ps
`default_nettype none
module video_output_ancillary_inserter_tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic pix_clk_in = 1'b0;
    logic [7:0] vid_in = 8'h60;
    logic anc_valid = 1'b0;
    logic [7:0] anc_data = 8'h00;
    logic anc_last = 1'b0;
    logic pll_lock = 1'b1;
    logic phase_jump = 1'b0;
    logic signed [3:0] jump_delta = 4'sh0;
    logic phase_jump_disable = 1'b0;
    logic irq_on_lock_pin_en = 1'b0;
    logic [7:0] irq_sources = 8'h01;
    logic [7:0] irq_mask = 8'h00;
    logic [7:0] pin_override_bits = 8'h00;
    logic [17:0] ctl = 18'h00000;
    logic anc_ready, pix_clk_out, hsync_pin, vsync_pin, field_pin, lock_pin, pll_fm_corr;
    logic [7:0] video_data_out;
    logic signed [3:0] pll_fm_delta;
    logic [1:0] eav_count;
    logic [7:0] cap [0:179];
    int line_px;
    int err_total = 0;
    int checks_done = 0;

    video_output_ancillary_inserter video_output_ancillary_inserter_inst (
        .clk(clk), .sys_rst(sys_rst), .pix_clk_in(pix_clk_in), .std_625(ctl[0]),
        .square_pix(ctl[1]), .vid_in(vid_in), .field_in(ctl[2]), .pll_lock(pll_lock),
        .phase_jump(phase_jump), .jump_delta(jump_delta), .anc_valid(anc_valid),
        .anc_ready(anc_ready), .anc_data(anc_data), .anc_last(anc_last),
        .vsync_mode_sel(ctl[3]), .phase_jump_disable(phase_jump_disable),
        .clock_edge_sel(ctl[4]), .force_interlace_en(ctl[5]), .vbi_bypass_en(ctl[6]),
        .hsync_delay_en(ctl[7]), .hsync_delay_sel(ctl[9:8]), .blank_behaviour_a(ctl[10]),
        .blank_behaviour_b(ctl[11]), .no_signal(ctl[12]), .atten_cb(ctl[14:13]),
        .atten_cr(ctl[16:15]), .clip_en(ctl[17]), .pin_override_bits(pin_override_bits),
        .irq_on_lock_pin_en(irq_on_lock_pin_en), .irq_sources(irq_sources),
        .irq_mask(irq_mask), .pix_clk_out(pix_clk_out), .video_data_out(video_data_out),
        .hsync_pin(hsync_pin), .vsync_pin(vsync_pin), .field_pin(field_pin),
        .lock_pin(lock_pin), .pll_fm_corr(pll_fm_corr), .pll_fm_delta(pll_fm_delta)
    );

    video_rx_model video_rx_model_inst (
        .pix_clk_out(pix_clk_out), .video_data_out(video_data_out),
        .eav_count(eav_count), .cap(cap), .line_px(line_px)
    );

    always #2 clk = ~clk;
    initial #13 forever #40 pix_clk_in = ~pix_clk_in;

    task automatic stop_test();
        if (err_total == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // hold the byte until an edge where ready was high
    task automatic push(input logic [7:0] d, input logic last);
        logic ok;
        anc_valid <= 1'b1;
        anc_data <= d;
        anc_last <= last;
        do
        begin
            @(negedge clk);
            ok = anc_ready;
            @(posedge clk);
        end while (ok !== 1'b1);
    endtask

    task automatic test_anc_push();
        for (int k = 0; k < 84; k++)
            push(8'h20 + 8'(k), 1'b0);
        push(8'h74, 1'b1);
        anc_valid <= 1'b0;
    endtask

    task automatic pin_case(input logic [7:0] ov, input logic [7:0] exp);
        pin_override_bits <= ov;
        repeat (60) @(posedge clk);
        check("pins", {4'h0, lock_pin, hsync_pin, vsync_pin, field_pin}, exp);
    endtask

    task automatic test_override();
        pin_case(8'h55, 8'h00);
        pin_case(8'h5F, 8'h0C);
        pin_case(8'hF5, 8'h03);
        pin_case(8'hFF, 8'h0F);
        pin_override_bits <= 8'h00;
    endtask

    task automatic lock_case(input logic pl, input logic en, input logic [7:0] m,
                             input logic exp);
        pll_lock <= pl;
        irq_on_lock_pin_en <= en;
        irq_mask <= m;
        repeat (60) @(posedge clk);
        check("lock", {7'h00, lock_pin}, {7'h00, exp});
    endtask

    task automatic test_lock_irq();
        lock_case(1'b1, 1'b0, 8'h01, 1'b1);
        lock_case(1'b0, 1'b0, 8'h01, 1'b0);
        lock_case(1'b1, 1'b1, 8'h00, 1'b0);
        lock_case(1'b0, 1'b1, 8'h01, 1'b1);
        lock_case(1'b1, 1'b0, 8'h00, 1'b1);
    endtask

    task automatic jump_case(input logic dis, input logic exp);
        @(posedge clk);
        phase_jump_disable <= dis;
        jump_delta <= 4'shD;
        phase_jump <= 1'b1;
        @(posedge clk);
        phase_jump <= 1'b0;
        #1;
        check("fm_corr", {3'h0, pll_fm_corr, exp ? pll_fm_delta : 4'hD}, {3'h0, exp, 4'hD});
        @(posedge clk);
        #1;
        check("fm_end", {7'h00, pll_fm_corr}, 8'h00);
    endtask

    task automatic test_phase_jump();
        jump_case(1'b1, 1'b1);
        jump_case(1'b0, 1'b0);
        phase_jump_disable <= 1'b0;
    endtask

    task automatic test_anc_check();
        while (eav_count !== 2'h2)
            @(posedge clk);
        repeat (2000) @(posedge clk);
        for (int k = 0; k < 84; k++)
            check("anc", cap[k], 8'h20 + 8'(k));
        check("blank", cap[84], 8'h80);
        check("next", cap[90], 8'h74);
        check("blank2", cap[91], 8'h10);
        check("line_len", 16'(line_px), 16'(vout_pkg::LEN_525N) - 16'h0003);
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        #1;
        check("video_rst", video_data_out, 8'h80);
        check("pins_rst", {4'h0, lock_pin, hsync_pin, vsync_pin, field_pin}, 8'h00);
        @(posedge clk);
        sys_rst <= 1'b0;
        test_anc_push();
        test_override();
        test_lock_irq();
        test_phase_jump();
        test_anc_check();
        stop_test();
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire
